// ---- src/sagenc_map.vh ----
`ifndef SAGENC_MAP_VH
`define SAGENC_MAP_VH
`define SAGENC_A_CTRL 12'h000
`define SAGENC_A_SRC 12'h004
`define SAGENC_A_STAT 12'h008
`define SAGENC_A_MASK 12'h00c
`define SAGENC_A_MON 12'h010
`define SAGENC_A_FORCE 12'h014
`define SAGENC_CTRL_RST 32'h0000_0000
`define SAGENC_MASK_RST 32'h0000_0000
`define SAGENC_CTRL_ARST_BIT 0
`define SAGENC_CTRL_ENA_BIT 1
`define SAGENC_MON_ITEM 8'h0f
`define SAGENC_GRP_NONE 3'h0
`define SAGENC_GRP_POWER 3'h1
`define SAGENC_GRP_LOAD 3'h2
`define SAGENC_GRP_ENC 3'h3
`define SAGENC_GRP_SUPPLY 3'h4
`define SAGENC_GRP_MOTION 3'h5
`define SAGENC_GRP_MEM 3'h6
`define SAGENC_GRP_SETUP 3'h7
`define SAGENC_NFAULT 36
`endif

// ---- src/sagenc_sync.v ----
`timescale 1ns/1ns
module sagenc_sync #(
    parameter W = 1
) (
    clk,
    srst,
    d,
    q
);
    input wire clk;
    input wire srst;
    input wire [W-1:0] d;
    output reg [W-1:0] q;
    reg [W-1:0] meta;
    always @(posedge clk) begin
        if (srst) begin
            meta <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // sagenc_sync

// ---- src/sagenc_top.v ----
// Contract
// - The summary alarm output is high whenever any alarm is latched, whatever its group.
// - The latched alarm is reported on three code lines as one of seven group numbers; the code stays 0 for faults 32 to 35.
// - Power-stage faults give code bits 0,1,2 = 1,0,0.
// - Cable-open, overload and overheat faults give code bits 0,1,2 = 0,1,0.
// - Encoder faults give code bits 0,1,2 = 1,1,0.
// - Supply voltage faults give code bits 0,1,2 = 0,0,1.
// - Motion and processor faults give code bits 0,1,2 = 1,0,1.
// - Communication and memory faults give code bits 0,1,2 = 0,1,1.
// - Capacity and setup faults give code bits 0,1,2 = 1,1,1.
// - Alarm presence is visible in a monitor register as display item fifteen.
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ns
`include "sagenc_map.vh"
module sagenc_top #(
    parameter NF = `SAGENC_NFAULT
) (
    clk,
    srst,
    fault_in,
    fwd_travel_limit_in,
    rev_travel_limit_in,
    alarm_reset_in,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    alarm_summary_out,
    fault_group_bit0,
    fault_group_bit1,
    fault_group_bit2,
    run_permit,
    irq
);
    input wire clk;
    input wire srst;
    input wire [NF-1:0] fault_in;
    input wire fwd_travel_limit_in;
    input wire rev_travel_limit_in;
    input wire alarm_reset_in;
    input wire psel;
    input wire penable;
    input wire pwrite;
    input wire [11:0] paddr;
    input wire [31:0] pwdata;
    output reg [31:0] prdata;
    output reg pready;
    output reg pslverr;
    output reg alarm_summary_out;
    output reg fault_group_bit0;
    output reg fault_group_bit1;
    output reg fault_group_bit2;
    output reg run_permit;
    output reg irq;

    // Fault index ranges per group, lowest index first
    function [2:0] grp_of;
        input integer i;
        begin
            if (i < 5)
                grp_of = `SAGENC_GRP_POWER;
            else if (i < 10)
                grp_of = `SAGENC_GRP_LOAD;
            else if (i < 17)
                grp_of = `SAGENC_GRP_ENC;
            else if (i < 20)
                grp_of = `SAGENC_GRP_SUPPLY;
            else if (i < 26)
                grp_of = `SAGENC_GRP_MOTION;
            else if (i < 30)
                grp_of = `SAGENC_GRP_MEM;
            else if (i < 32)
                grp_of = `SAGENC_GRP_SETUP;
            else
                grp_of = `SAGENC_GRP_NONE;
        end
    endfunction

    wire [NF-1:0] fault_s;
    wire [2:0] ctl_s;
    sagenc_sync #(.W(NF)) u_sync_f (
        .clk(clk),
        .srst(srst),
        .d(fault_in),
        .q(fault_s)
    );
    sagenc_sync #(.W(3)) u_sync_c (
        .clk(clk),
        .srst(srst),
        .d({alarm_reset_in, rev_travel_limit_in, fwd_travel_limit_in}),
        .q(ctl_s)
    );

    // Software side of the block
    reg [31:0] ctrl;
    reg [NF-1:0] force_flt;
    reg [NF-1:0] mask;
    reg sw_ares;

    // Alarm state
    reg [NF-1:0] latched;
    reg [2:0] group;
    reg ares_d;

    wire ares_pulse;
    wire [NF-1:0] src;
    wire [NF-1:0] stat_clr;
    wire [NF-1:0] next_latched;
    wire any_alarm;
    wire acc;
    wire wr;
    wire rd;
    wire [5:0] wsel;
    wire [5:0] rsel;

    // Bus words are 32 bits while the fault vector may be wider or narrower;
    // the extended copies keep every slice in range whatever NF is
    wire [NF+31:0] pw_ext;
    wire [NF+31:0] src_ext;
    wire [NF+31:0] lat_ext;
    wire [NF+31:0] mask_ext;
    wire [NF+31:0] force_ext;

    localparam SEL_CTRL = 0;
    localparam SEL_SRC = 1;
    localparam SEL_STAT = 2;
    localparam SEL_MASK = 3;
    localparam SEL_MON = 4;
    localparam SEL_FORCE = 5;

    // Bus slave states, one-hot
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_ANS = 2'b10;
    reg [1:0] state;
    reg [1:0] next_state;

    // One select bit per register, none for an unmapped offset
    function [5:0] reg_sel;
        input [11:0] a;
        begin
            case (a)
                `SAGENC_A_CTRL: reg_sel = 6'h01;
                `SAGENC_A_SRC: reg_sel = 6'h02;
                `SAGENC_A_STAT: reg_sel = 6'h04;
                `SAGENC_A_MASK: reg_sel = 6'h08;
                `SAGENC_A_MON: reg_sel = 6'h10;
                `SAGENC_A_FORCE: reg_sel = 6'h20;
                default: reg_sel = 6'h00;
            endcase
        end
    endfunction

    // Source and monitor words are read only, a write there is refused
    function wr_ok;
        input [5:0] s;
        begin
            wr_ok = s[SEL_CTRL] | s[SEL_STAT] | s[SEL_MASK] | s[SEL_FORCE];
        end
    endfunction

    assign acc = psel & penable & ~pready;
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite;
    assign wsel = reg_sel(paddr) & {6{wr}};
    assign rsel = reg_sel(paddr) & {6{rd}};

    assign pw_ext = {{NF{1'b0}}, pwdata};
    assign src_ext = {32'h0000_0000, src};
    assign lat_ext = {32'h0000_0000, latched};
    assign mask_ext = {32'h0000_0000, mask};
    assign force_ext = {32'h0000_0000, force_flt};

    // Forced bits let software exercise every group without a real cause
    assign src = fault_s | force_flt;
    assign any_alarm = |latched;
    // The pin resets on its rising edge only, so a held level cannot keep
    // wiping alarms that arrive later
    assign ares_pulse = (ctl_s[2] & ~ares_d) | sw_ares;
    // Faults above bit 31 cannot be cleared by a status write, only by reset
    assign stat_clr = wsel[SEL_STAT] ? pw_ext[NF-1:0] : {NF{1'b0}};

    // Per-fault latch: a live cause sets its bit again in the very cycle
    // it is cleared, so the set wins over both kinds of clear
    genvar gi;
    generate
        for (gi = 0; gi < NF; gi = gi + 1) begin : g_latch
            assign next_latched[gi] = (ares_pulse | stat_clr[gi]) ? src[gi] :
                (latched[gi] | src[gi]);
        end
    endgenerate

    always @(posedge clk) begin
        if (srst) begin
            latched <= {NF{1'b0}};
            ares_d <= 1'b0;
        end else begin
            ares_d <= ctl_s[2];
            latched <= next_latched;
        end
    end

    // Lowest-numbered group wins when several groups are latched; the host
    // sees only one code, the status word keeps the rest
    reg [2:0] next_group;
    integer k;
    always @* begin
        next_group = `SAGENC_GRP_NONE;
        for (k = NF - 1; k >= 0; k = k - 1) begin
            if (latched[k] && grp_of(k) != `SAGENC_GRP_NONE)
                next_group = grp_of(k);
        end
    end

    // Run needs no alarm, both travel limits on and software enable
    reg next_run;
    always @* begin
        next_run = ~any_alarm;
        if (!ctl_s[0] || !ctl_s[1])
            next_run = 1'b0;
        if (!ctrl[`SAGENC_CTRL_ENA_BIT])
            next_run = 1'b0;
    end

    // Summary and code come from the same latched vector on one edge,
    // so the host never sees a code that disagrees with the summary
    always @(posedge clk) begin
        if (srst) begin
            group <= `SAGENC_GRP_NONE;
            alarm_summary_out <= 1'b0;
            fault_group_bit0 <= 1'b0;
            fault_group_bit1 <= 1'b0;
            fault_group_bit2 <= 1'b0;
            run_permit <= 1'b0;
            irq <= 1'b0;
        end else begin
            group <= next_group;
            alarm_summary_out <= any_alarm;
            fault_group_bit0 <= next_group[0];
            fault_group_bit1 <= next_group[1];
            fault_group_bit2 <= next_group[2];
            run_permit <= next_run;
            irq <= |(latched & mask);
        end
    end

    // One wait state: the answer stands the edge after the access phase starts
    always @* begin
        case (state)
            ST_IDLE: begin
                if (acc)
                    next_state = ST_ANS;
                else
                    next_state = ST_IDLE;
            end
            ST_ANS: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // Unmapped offsets and writes to read-only words answer with an error
    reg next_err;
    always @* begin
        next_err = 1'b0;
        if (wr && !wr_ok(reg_sel(paddr)))
            next_err = 1'b1;
        if (rd && reg_sel(paddr) == 6'h00)
            next_err = 1'b1;
    end

    always @(posedge clk) begin
        if (srst) begin
            state <= ST_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            state <= next_state;
            pready <= (next_state == ST_ANS);
            pslverr <= next_err;
        end
    end

    // Writes land on the first access edge; the reset bit is a one-cycle pulse
    always @(posedge clk) begin
        if (srst) begin
            ctrl <= `SAGENC_CTRL_RST;
            mask <= {NF{1'b0}};
            force_flt <= {NF{1'b0}};
            sw_ares <= 1'b0;
        end else begin
            sw_ares <= wsel[SEL_CTRL] & pwdata[`SAGENC_CTRL_ARST_BIT];
            if (wsel[SEL_CTRL])
                ctrl <= {30'h0000_0000, pwdata[1:0]};
            if (wsel[SEL_MASK])
                mask <= pw_ext[NF-1:0];
            if (wsel[SEL_FORCE])
                force_flt <= pw_ext[NF-1:0];
        end
    end

    // Read words carry the low 32 fault bits only
    reg [31:0] next_prdata;
    always @* begin
        next_prdata = 32'h0000_0000;
        case (1'b1)
            rsel[SEL_CTRL]: next_prdata = {30'h0000_0000, ctrl[`SAGENC_CTRL_ENA_BIT], 1'b0};
            rsel[SEL_SRC]: next_prdata = src_ext[31:0];
            rsel[SEL_STAT]: next_prdata = lat_ext[31:0];
            rsel[SEL_MASK]: next_prdata = mask_ext[31:0];
            rsel[SEL_FORCE]: next_prdata = force_ext[31:0];
            rsel[SEL_MON]: next_prdata = {20'h0_0000, any_alarm, group, `SAGENC_MON_ITEM};
            default: next_prdata = 32'h0000_0000;
        endcase
    end

    always @(posedge clk) begin
        if (srst)
            prdata <= 32'h0000_0000;
        else if (rd)
            prdata <= next_prdata;
    end
endmodule // sagenc_top

// ---- testbench/sagenc_checker.sv ----
`timescale 1ns/1ns
module sagenc_checker #(parameter NF = 36) (
    input wire clk, srst, psel, penable, pready, pslverr, irq, run_permit,
    input wire [NF-1:0] fault_in,
    input wire alarm_summary_out, fault_group_bit0, fault_group_bit1, fault_group_bit2
);
    wire [2:0] code = {fault_group_bit2, fault_group_bit1, fault_group_bit0};
    reg [2:0] lg;
    // Lowest group present wins when several causes are live
    always @* lg = |fault_in[4:0] ? 3'h1 : |fault_in[9:5] ? 3'h2 : |fault_in[16:10] ? 3'h3 :
        |fault_in[19:17] ? 3'h4 : |fault_in[25:20] ? 3'h5 : |fault_in[29:26] ? 3'h6 :
        |fault_in[31:30] ? 3'h7 : 3'h0;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    summary_code_a: assert property (!alarm_summary_out |-> code == 3'h0)
        else $error("group code without alarm");
    alarm_raise_a: assert property ((|fault_in)[*6] |-> alarm_summary_out)
        else $error("alarm missed");
    group_bound_a: assert property ((lg != 0 && $stable(fault_in))[*6] |->
        code != 3'h0 && code <= lg) else $error("wrong group");
    irq_alarm_a: assert property (irq |-> alarm_summary_out) else $error("irq w/o alarm");
    run_block_a: assert property (run_permit |-> !alarm_summary_out)
        else $error("run during alarm");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready stuck");
    wait_state_a: assert property (psel && penable && !pready |=> pready)
        else $error("no answer");
    err_ready_a: assert property (pslverr |-> pready) else $error("stray error");
    cover property ($rose(irq));
    cover property (pslverr);
    cover property ($rose(run_permit));
endmodule // sagenc_checker
bind sagenc_top sagenc_checker #(.NF(NF)) chk (.clk, .srst, .psel, .penable, .pready,
    .pslverr, .irq, .run_permit, .fault_in, .alarm_summary_out, .fault_group_bit0,
    .fault_group_bit1, .fault_group_bit2);

// ---- testbench/sagenc_host.sv ----
`timescale 1ns/1ns
module sagenc_host (
    input wire clk, clr_req, alarm_summary_out,
    input wire fault_group_bit0, fault_group_bit1, fault_group_bit2,
    output reg fwd_travel_limit_in = 1,
    output reg rev_travel_limit_in = 1,
    output reg alarm_reset_in = 0,
    output reg [2:0] seen_group = 0,
    output reg seen_alarm = 0
);
    // Reset is only requested by the bench once the cause is gone
    always @(posedge clk) begin
        alarm_reset_in <= clr_req;
        seen_alarm <= alarm_summary_out;
        seen_group <= {fault_group_bit2, fault_group_bit1, fault_group_bit0};
    end
endmodule // sagenc_host

// ---- testbench/sagenc_top_tb_top.sv ----
`timescale 1ns/1ns
module sagenc_top_tb_top;
    reg clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, clr = 0, e;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0, r;
    reg [35:0] fault_in = 0;
    reg [41:0] idx = {6'd30, 6'd26, 6'd20, 6'd17, 6'd10, 6'd5, 6'd0};
    wire [31:0] prdata;
    wire [2:0] grp;
    wire pready, pslverr, alarm_summary_out, fault_group_bit0, fault_group_bit1;
    wire fault_group_bit2, run_permit, irq, seen;
    wire fwd_travel_limit_in, rev_travel_limit_in, alarm_reset_in;
    integer failures = 0, samples_checked = 0, g;
    always #20 clk = ~clk;
    sagenc_top #(.NF(36)) uut (.clk, .srst, .fault_in, .fwd_travel_limit_in,
        .rev_travel_limit_in, .alarm_reset_in, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .alarm_summary_out, .fault_group_bit0,
        .fault_group_bit1, .fault_group_bit2, .run_permit, .irq);
    sagenc_host host (.clk, .clr_req(clr), .alarm_summary_out, .fault_group_bit0,
        .fault_group_bit1, .fault_group_bit2, .fwd_travel_limit_in, .rev_travel_limit_in,
        .alarm_reset_in, .seen_group(grp), .seen_alarm(seen));
    task results;
        if (failures == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input [32:0] s, input [32:0] x);
        samples_checked = samples_checked + 1;
        if (s !== x) begin
            failures = failures + 1;
            $display("BAD %0t got %h want %h", $time, s, x);
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk) penable <= 1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    task wt;
        repeat (8) @(posedge clk);
    endtask
    task clear;
        fault_in <= 0;
        wt;
        clr <= 1;
        @(posedge clk) clr <= 0;
        wt;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        srst <= 0;
        apb(0, 12'h000, 0); chk(r, 0);
        apb(0, 12'h00c, 0); chk(r, 0);
        apb(0, 12'h010, 0); chk(r, 32'h0000_000f);
        apb(0, 12'h018, 0); chk({e, r}, 33'h1_0000_0000);
        for (g = 1; g < 8; g = g + 1) begin
            fault_in <= 36'h1 << idx[g*6-6 +: 6];
            wt;
            chk({seen, grp}, {1'b1, g[2:0]});
            apb(0, 12'h010, 0); chk(r, {1'b1, g[2:0], 8'h0f});
            clear;
            chk({seen, grp}, 0);
        end
        fault_in <= 36'h1_0000_0000;
        wt;
        chk({seen, grp}, 4'h8);
        clear;
        apb(1, 12'h00c, 2);
        fault_in <= 2;
        wt;
        chk(irq, 1);
        apb(1, 12'h00c, 0); wt; chk(irq, 0);
        apb(1, 12'h00c, 2);
        fault_in <= 0;
        wt;
        apb(1, 12'h008, 2); wt; chk(irq, 0);
        clear;
        fault_in <= 36'h0_4000_0400;
        wt;
        chk(grp, 3);
        clear;
        apb(1, 12'h000, 2); wt; chk({seen, run_permit}, 1);
        apb(1, 12'h014, 32'h0000_0020); wt;
        apb(0, 12'h004, 0); chk(r, 32'h0000_0020);
        chk({seen, grp}, 4'ha);
        chk(run_permit, 0);
        apb(1, 12'h014, 0);
        apb(1, 12'h000, 3); wt; chk({seen, grp, run_permit}, 1);
        srst <= 1;
        repeat (2) @(posedge clk);
        srst <= 0;
        @(posedge clk);
        chk({alarm_summary_out, run_permit, irq, pready}, 0);
        results;
    end
    initial begin
        #200000;
        failures = failures + 1;
        results;
    end
endmodule // sagenc_top_tb_top
